// *** dsp_vector_right_shifter.sv ***
`include "shifter_defs.svh"
module dsp_vector_right_shifter
  import shifter_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        issue_valid,
  input  wire logic [31:0] instr_word,
  input  wire logic [31:0] src_one_value,
  input  wire logic [31:0] src_two_value,
  input  wire logic        dsp_enable,
  output logic [31:0]      result_data,
  output logic             result_write,
  output logic [4:0]       dest_index,
  output logic             reserved_trap,
  output logic             dsp_disabled_trap
);
  // =====================================================
  // Decode.
  op_kind_type kind;
  logic        round_sel;
  logic [10:0] minor;
  logic [5:0]  ext;
  logic [5:0]  sub;
  logic [4:0]  dest_sel;
  lane_if      lanes ();
  state_type   st_q;
  state_type   st_d;

  assign minor = instr_word[`MINOR_MSB:`MINOR_LSB];
  assign ext   = instr_word[`EXT_MSB:`EXT_LSB];
  assign sub   = instr_word[`SUB_MSB:`SUB_LSB];

  always_comb begin
    kind      = op_none;
    round_sel = 1'b0;
    dest_sel  = instr_word[`DEST_MSB:`DEST_LSB];
    if (instr_word[`MAJOR_MSB:`MAJOR_LSB] != `MAJOR_GROUP_ZERO) begin
      kind = op_none;
    end else if (minor == `OP_HALF_ASV) begin
      kind = op_half_arith;
    end else if (minor == `OP_HALF_ARSV) begin
      kind      = op_half_arith;
      round_sel = 1'b1;
    end else if (minor == `OP_BYTE_ASV) begin
      kind = op_byte_arith;
    end else if (minor == `OP_BYTE_ARSV) begin
      kind      = op_byte_arith;
      round_sel = 1'b1;
    end else if (minor == `OP_WORD_ARSV) begin
      kind      = op_word_round_var;
      round_sel = 1'b1;
    end else if (minor == `OP_WORD_ARSI) begin
      kind      = op_word_round_imm;
      round_sel = 1'b1;
      dest_sel  = instr_word[`SRC_TWO_MSB:`SRC_TWO_LSB];
    end else if (sub == `SUB_HALF_LSI && ext == `EXTENDED_MINOR_GROUP) begin
      kind     = op_half_logic_imm;
      dest_sel = instr_word[`SRC_TWO_MSB:`SRC_TWO_LSB];
    end
  end

  // =====================================================
  // Operand steering.
  always_comb begin
    lanes.operand   = src_two_value;
    lanes.count     = src_one_value[4:0];
    lanes.lane_size = 2'd2;
    lanes.arith     = 1'b1;
    lanes.round     = round_sel;
    case (kind)
      op_word_round_imm: begin
        lanes.operand = src_one_value;
        lanes.count   = instr_word[`IMM5_MSB:`IMM5_LSB];
      end
      op_half_arith: begin
        lanes.lane_size = 2'd1;
        lanes.count     = {1'b0, src_one_value[3:0]};
      end
      op_byte_arith: begin
        lanes.lane_size = 2'd0;
        lanes.count     = {2'b00, src_one_value[2:0]};
      end
      op_half_logic_imm: begin
        lanes.operand   = src_one_value;
        lanes.lane_size = 2'd1;
        lanes.arith     = 1'b0;
        lanes.count     = {1'b0, instr_word[`IMM4_MSB:`IMM4_LSB]};
      end
      default: begin
        lanes.round = round_sel;
      end
    endcase
  end

  lane_shift_unit u_lane (
    .lanes (lanes.unit)
  );

  // =====================================================
  // Result register.
  always_comb begin
    st_d      = '0;
    st_d.dest = st_q.dest;
    if (issue_valid) begin
      st_d.dest = dest_sel;
      if (kind == op_none) begin
        st_d.ri_trap = 1'b1;
      end else if (!dsp_enable) begin
        st_d.dsp_trap = 1'b1;
      end else begin
        st_d.result = lanes.result;
        st_d.wr_en  = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign result_data       = st_q.result;
  assign result_write      = st_q.wr_en;
  assign reserved_trap     = st_q.ri_trap;
  assign dsp_disabled_trap = st_q.dsp_trap;
  assign dest_index        = st_q.dest;
endmodule

// *** issue_model.sv ***
// ==========
// Issue stage model.
module issue_model (
  input wire logic core_clk,
  output logic        issue_valid,
  output logic [31:0] instr_word,
  output logic [31:0] src_one_value,
  output logic [31:0] src_two_value,
  output logic        dsp_enable
);
  initial begin
    issue_valid = 1'h0;
    instr_word = 32'h0000_0000;
    src_one_value = 32'h0000_0000;
    src_two_value = 32'h0000_0000;
    dsp_enable = 1'h1;
  end
  task automatic send(input logic [31:0] i, a, b, input logic en);
    issue_valid = 1'h1;
    instr_word = i;
    src_one_value = a;
    src_two_value = b;
    dsp_enable = en;
  endtask
  task automatic idle;
    issue_valid = 1'h0;
    instr_word = ~instr_word;
    src_one_value = ~src_one_value;
    src_two_value = ~src_two_value;
  endtask
endmodule

// *** lane_if.sv ***
interface lane_if;
  logic [31:0] operand;
  logic [4:0]  count;
  logic [1:0]  lane_size;
  logic        arith;
  logic        round;
  logic [31:0] result;
  modport core (output operand, count, lane_size, arith, round,
                input result);
  modport unit (input operand, count, lane_size, arith, round,
                output result);
endinterface

// *** lane_shift_unit.sv ***
module lane_shift_unit (
  lane_if.unit lanes
);
  // =====================================================
  // Per-lane shifter with element widths of 8, 16 or 32 bits.
  logic [31:0] word_res;
  logic [31:0] half_res;
  logic [31:0] byte_res;

  function automatic logic [31:0] shr_elem(input logic [31:0] a,
                                           input logic [4:0]  s,
                                           input int          w,
                                           input logic        ar,
                                           input logic        rn);
    logic [32:0] ext;
    logic [32:0] sum;
    logic        sgn;
    ext = '0;
    sum = '0;
    sgn = ar & a[w-1];
    if (s == 5'h0) begin
      shr_elem = a;
    end else begin
      for (int i = 0; i <= 32; i++) begin
        if (i <= w) begin
          if (i + int'(s) - 1 < w) ext[i] = (i + int'(s) == 0) ? 1'b0 :
                                            a[i + int'(s) - 1];
          else ext[i] = sgn;
        end
      end
      sum = ext + (rn ? 33'h0_0000_0001 : 33'h0);
      shr_elem = sum[32:1] & ((w == 32) ? 32'hFFFF_FFFF :
                 ((32'h0000_0001 << w) - 32'h0000_0001));
    end
  endfunction

  assign word_res = shr_elem(lanes.operand, lanes.count, 32, lanes.arith,
                             lanes.round);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_half
      logic [31:0] t;
      assign t = shr_elem({16'h0000, lanes.operand[16*g +: 16]},
                          {1'b0, lanes.count[3:0]}, 16, lanes.arith,
                          lanes.round);
      assign half_res[16*g +: 16] = t[15:0];
    end
    for (g = 0; g < 4; g++) begin : g_byte
      logic [31:0] t;
      assign t = shr_elem({24'h00_0000, lanes.operand[8*g +: 8]},
                          {2'b00, lanes.count[2:0]}, 8, lanes.arith,
                          lanes.round);
      assign byte_res[8*g +: 8] = t[7:0];
    end
  endgenerate

  assign lanes.result = (lanes.lane_size == 2'd2) ? word_res :
                        (lanes.lane_size == 2'd1) ? half_res : byte_res;
endmodule

// *** shifter_chk.sv ***
// ==========
// Checker.
module shifter_chk (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        issue_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] src_one_value,
  input wire logic [31:0] src_two_value,
  input wire logic        dsp_enable,
  input wire logic [31:0] result_data,
  input wire logic        result_write,
  input wire logic [4:0]  dest_index,
  input wire logic        reserved_trap,
  input wire logic        dsp_disabled_trap
);
  logic m0, hlf, byt, lgc, wrd, known;
  assign m0 = instr_word[31:26] == 6'h00;
  assign hlf = m0 && instr_word[9:0] == 10'h18d;
  assign byt = m0 && instr_word[9:0] == 10'h1cd;
  assign lgc = m0 && instr_word[11:0] == 12'h3fc;
  assign wrd = m0 && (instr_word[10:0] == 11'h095 ||
                      instr_word[10:0] == 11'h2f5);
  assign known = hlf | byt | lgc | wrd;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  AST_ONE_ANSWER: assert property (issue_valid |=>
    $onehot({result_write, reserved_trap, dsp_disabled_trap}))
    else $error("not exactly one answer");
  AST_IDLE: assert property (!issue_valid |=>
    !(result_write | reserved_trap | dsp_disabled_trap))
    else $error("answer without request");
  AST_RESERVED: assert property (issue_valid && !known |=>
    reserved_trap) else $error("unknown code accepted");
  AST_DISABLED: assert property (issue_valid && known &&
    !dsp_enable |=> dsp_disabled_trap && !result_write)
    else $error("disabled extension wrote");
  AST_NO_DATA_TRAP: assert property (issue_valid && known &&
    dsp_enable |=> result_write) else $error("data trap raised");
  AST_HALF_ZERO: assert property (issue_valid && hlf &&
    dsp_enable && src_one_value[3:0] == 4'h0 |=>
    result_data == $past(src_two_value)) else $error("zero count changed");
  AST_LOGIC_TOP: assert property (issue_valid && lgc &&
    dsp_enable && instr_word[15:12] != 4'h0 |=>
    !result_data[31] && !result_data[15]) else $error("no zero fill");
  AST_BYTE_SIGN: assert property (issue_valid && byt &&
    !instr_word[10] && dsp_enable && src_one_value[2:0] == 3'h7 |=>
    result_data[31:24] == {8{$past(src_two_value[31])}})
    else $error("byte sign fill wrong");
  cover property (issue_valid && hlf && instr_word[10]);
  cover property (issue_valid && !known);
  cover property (issue_valid && known && !dsp_enable);
endmodule
bind dsp_vector_right_shifter shifter_chk i_chk (.*);

// *** shifter_defs.svh ***
`ifndef SHIFTER_DEFS_SVH
`define SHIFTER_DEFS_SVH

// =====================================================
// Encoding fields.
`define MAJOR_GROUP_ZERO       6'h00
`define MAJOR_MSB              31
`define MAJOR_LSB              26
`define SRC_TWO_MSB            25
`define SRC_TWO_LSB            21
`define SRC_ONE_MSB            20
`define SRC_ONE_LSB            16
`define DEST_MSB               15
`define DEST_LSB               11
`define MINOR_MSB              10
`define MINOR_LSB              0
`define EXT_MSB                5
`define EXT_LSB                0
`define SUB_MSB                11
`define SUB_LSB                6
`define IMM4_MSB               15
`define IMM4_LSB               12
`define IMM5_MSB               15
`define IMM5_LSB               11
`define OP_HALF_ASV            11'b00110001101
`define OP_HALF_ARSV           11'b10110001101
`define OP_BYTE_ASV            11'b00111001101
`define OP_BYTE_ARSV           11'b10111001101
`define EXTENDED_MINOR_GROUP   6'b111100
`define SUB_HALF_LSI           6'b001111
`define OP_WORD_ARSV           11'b00010010101
`define OP_WORD_ARSI           11'b01011110101
`endif

// *** shifter_pkg.sv ***
package shifter_pkg;
  typedef enum logic [2:0] {
    op_none,
    op_word_round_imm,
    op_word_round_var,
    op_half_arith,
    op_byte_arith,
    op_half_logic_imm
  } op_kind_type;

  typedef struct packed {
    logic [31:0] result;
    logic        wr_en;
    logic        ri_trap;
    logic        dsp_trap;
    logic [4:0]  dest;
  } state_type;
endpackage

// *** testbench.sv ***
// ==========
// Testbench.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'h0;
  logic        srst = 1'h1;
  logic        issue_valid, dsp_enable, result_write;
  logic        reserved_trap, dsp_disabled_trap;
  logic [31:0] instr_word, src_one_value, src_two_value, result_data;
  logic [4:0]  dest_index;
  int          failures = 0;
  int          checked = 0;
  int          cycles = 0;
  always #12.5 core_clk = ~core_clk;
  issue_model i_model (.*);
  dsp_vector_right_shifter i_dut (.*);
  function automatic logic [31:0] rf(logic [31:0] v, int w, s, bit ar, rn);
    longint e, m;
    logic [31:0] r;
    m = (longint'(1) << w) - 1;
    r = 32'h0000_0000;
    for (int l = 0; l < 32 / w; l++) begin
      e = (v >> (l * w)) & m;
      if (ar && e[w-1]) e -= m + 1;
      e = (rn && s > 0) ? ((e >>> (s - 1)) + 1) >>> 1 : e >>> s;
      r |= 32'((e & m) << (l * w));
    end
    return r;
  endfunction
  task automatic chk(input logic [39:0] got, exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic run(input logic [31:0] i, a, b, e, input logic [4:0] d,
                     input logic [2:0] f);
    i_model.send(i, a, b, f != 3'h1);
    @(posedge core_clk);
    #1;
    chk({37'h0, result_write, reserved_trap, dsp_disabled_trap}, {37'h0, f});
    if (f == 3'h4) chk({result_data, 3'h0, dest_index}, {e, 3'h0, d});
  endtask
  task automatic t_vec;
    int cs[3] = '{0, 1, 15};
    for (int r = 0; r < 2; r++) begin
      foreach (cs[k]) begin
        run({16'h0064, 5'h05, r ? 11'h58d : 11'h18d}, 32'hfff0_0000 | cs[k],
          32'h8001_7fff, rf(32'h8001_7fff, 16, cs[k], 1, r), 5'h05,
          3'h4);
        run({16'h0064, 5'h05, r ? 11'h5cd : 11'h1cd}, 32'hffff_fff8 | cs[k]/2,
          32'h80ff_7f41, rf(32'h80ff_7f41, 8, cs[k]/2, 1, r), 5'h05,
          3'h4);
      end
    end
    $display("vector tests done");
  endtask
  task automatic t_word;
    int cs[3] = '{0, 1, 31};
    foreach (cs[k]) begin
      run({16'h0064, 5'h05, 11'h095}, 32'hffff_ffe0 | cs[k], 32'h8000_0003,
        rf(32'h8000_0003, 32, cs[k], 1, 1), 5'h05, 3'h4);
      run({16'h0064, 5'(cs[k]), 11'h2f5}, 32'h8000_0003, 32'h0000_0000,
        rf(32'h8000_0003, 32, cs[k], 1, 1), 5'h03, 3'h4);
      run({16'h0064, 4'(cs[k] / 2), 12'h3fc}, 32'h8001_fffe, 32'h0000_0000,
        rf(32'h8001_fffe, 16, cs[k] / 2, 0, 0), 5'h03, 3'h4);
    end
    $display("word and logical tests done");
  endtask
  task automatic t_trap;
    run({16'h0064, 5'h05, 11'h7ff}, 32'h0, 32'h0, 32'h0, 5'h00, 3'h2);
    run({16'h0064, 5'h05, 11'h18d}, 32'h1, 32'h0, 32'h0, 5'h00, 3'h1);
    $display("trap tests done");
  endtask
  task automatic t_reset;
    i_model.send({16'h0064, 5'h05, 11'h18d}, 32'h0000_0000, 32'h1234_5678,
                 1'h1);
    srst = 1'h1;
    @(posedge core_clk);
    #1;
    chk({result_data, result_write, reserved_trap, dsp_disabled_trap,
         dest_index}, 40'h00_0000_0000);
    srst = 1'h0;
    $display("reset test done");
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 2000) begin
      failures++;
      results();
    end
  end
  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    srst = 1'h0;
    t_vec();
    t_word();
    t_reset();
    t_trap();
    i_model.idle();
    @(posedge core_clk);
    #1;
    results();
  end
endmodule
